/* verification/rsc_core_model.sv */
/*
  Processor core model: single byte register writes and reads.
  Assumes callers issue requests only while the system reset is low.
*/
`timescale 1ns/1ns
module rsc_core_model (
  // Clock and read data
  input wire i_mclk,
  input wire [7:0] i_rdata,
  // Bus requests
  output reg [7:0] o_addr = 8'h00,
  output reg o_wr = 1'b0,
  output reg o_rd = 1'b0,
  output reg [7:0] o_wdata = 8'h00
);
  // Released lines show the inverse, never a stale value
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge i_mclk);
      o_addr = a;
      o_wdata = d;
      o_wr = 1'b1;
      @(negedge i_mclk);
      o_wr = 1'b0;
      o_addr = ~a;
      o_wdata = ~d;
    end
  endtask
  task rd(input [7:0] a, output [7:0] d);
    begin
      @(negedge i_mclk);
      o_addr = a;
      o_rd = 1'b1;
      @(negedge i_mclk);
      d = i_rdata;
      o_rd = 1'b0;
      o_addr = ~a;
    end
  endtask
endmodule

/* verification/rsc_ctrl_asserts.sv */
/*
  Checker of the reset source controller port behaviour.
  Assumes binding to rsc_ctrl; i_rst is the power-on reset.
*/
`timescale 1ns/1ns
module rsc_ctrl_asserts (
  // Clock and reset
  input wire i_mclk,
  input wire i_rst,
  // Register bus
  input wire [7:0] i_sfr_addr,
  input wire i_sfr_wr,
  input wire i_sfr_rd,
  input wire [7:0] i_sfr_wdata,
  input wire [7:0] o_sfr_rdata,
  // Sources and outputs
  input wire i_rst_pin_n,
  input wire o_rst_pin_out,
  input wire o_rst_pin_oe,
  input wire i_supply_above,
  input wire o_supply_monitor_enable,
  input wire o_supply_threshold_select,
  input wire i_wdt_expire,
  input wire o_wdt_tick,
  input wire i_code_rd,
  input wire [1:0] i_bank,
  input wire [15:0] i_addr,
  input wire o_sys_rst
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  wire rd_mon = i_sfr_rd && i_sfr_addr == 8'hFF && !o_sys_rst;
  wire sw_wr = i_sfr_wr && i_sfr_addr == 8'hEF && i_sfr_wdata[4] && !o_sys_rst;
  a_pin_out_low: assert property (o_rst_pin_out == 1'b0) else $error("reset pin driven high");
  a_sw_no_pin: assert property (sw_wr && i_rst_pin_n && i_supply_above |=> !o_rst_pin_oe [*6])
    else $error("software reset touched the pin");
  a_sw_forces: assert property (sw_wr |-> ##[1:3] o_sys_rst) else $error("force bit gave no reset");
  a_mon_unused: assert property (rd_mon |=> o_sfr_rdata[4:0] == 5'h00) else $error("unused bits set");
  a_mon_fields: assert property (rd_mon |=> o_sfr_rdata[7] == $past(o_supply_monitor_enable) &&
    o_sfr_rdata[5] == $past(o_supply_threshold_select)) else $error("monitor fields differ from outputs");
  a_status_live: assert property ($stable(i_supply_above) [*4] ##0 rd_mon |=>
    o_sfr_rdata[6] == $past(i_supply_above)) else $error("status bit not live");
  a_pin_resets: assert property (!i_rst_pin_n [*6] |-> o_sys_rst) else $error("pin low without reset");
  a_wdt_period: assert property (o_wdt_tick && !o_sys_rst ##1 !o_sys_rst [*8] ##1 !o_sys_rst [*3]
    |=> o_wdt_tick) else $error("watchdog tick not every 12 clocks");
  a_wdt_resets: assert property (i_wdt_expire && !o_sys_rst |-> ##[1:3] o_sys_rst)
    else $error("watchdog expiry gave no reset");
  a_code_fault: assert property (i_code_rd && i_bank == 2'h3 && i_addr > 16'hFBFF && !o_sys_rst
    |-> ##[1:4] o_sys_rst) else $error("code read fault gave no reset");
endmodule
bind rsc_ctrl rsc_ctrl_asserts chk_u (.i_mclk, .i_rst, .i_sfr_addr, .i_sfr_wr, .i_sfr_rd, .i_sfr_wdata,
  .o_sfr_rdata, .i_rst_pin_n, .o_rst_pin_out, .o_rst_pin_oe, .i_supply_above, .o_supply_monitor_enable,
  .o_supply_threshold_select, .i_wdt_expire, .o_wdt_tick, .i_code_rd, .i_bank, .i_addr, .o_sys_rst);

/* verification/tb_top.sv */
/*
  Self-checking bench of the reset source controller.
  Assumes the core model drives the register bus; other inputs come from here.
*/
`timescale 1ns/1ns
module tb_top;
  reg i_mclk = 1'b0;
  reg i_rst = 1'b1;
  reg i_rst_pin_n = 1'b1, i_supply_above = 1'b1, i_cmp_out = 1'b1, i_sysclk_probe = 1'b0, i_wdt_expire = 1'b0;
  reg i_program_store_write_enable = 1'b0, i_data_wr = 1'b0, i_code_rd = 1'b0, i_fetch = 1'b0, i_flash_op = 1'b0, i_secure_deny = 1'b0;
  reg [1:0] i_bank = 2'h0, i_fetch_bank = 2'h0;
  reg [15:0] i_addr = 16'h0000, i_fetch_addr = 16'h0000;
  reg probe_run = 1'b1;
  wire [7:0] i_sfr_addr, i_sfr_wdata, o_sfr_rdata;
  wire i_sfr_wr, i_sfr_rd, o_rst_pin_out, o_rst_pin_oe, o_supply_monitor_enable, o_supply_threshold_select;
  wire o_wdt_tick, o_sys_rst;
  integer seed = 82687, err_count = 0, checked = 0, m_en = 1, m_lvl = 0, k, r;
  reg [7:0] d;
  rsc_ctrl dut_u (.i_mclk, .i_rst, .i_sfr_addr, .i_sfr_wr, .i_sfr_rd, .i_sfr_wdata, .o_sfr_rdata,
    .i_rst_pin_n, .o_rst_pin_out, .o_rst_pin_oe, .i_supply_above, .o_supply_monitor_enable,
    .o_supply_threshold_select, .i_cmp_out, .i_sysclk_probe, .i_wdt_expire, .o_wdt_tick, .i_program_store_write_enable, .i_data_wr,
    .i_code_rd, .i_fetch, .i_flash_op, .i_secure_deny, .i_bank, .i_addr, .i_fetch_bank, .i_fetch_addr, .o_sys_rst);
  rsc_core_model core_u (.i_mclk, .i_rdata(o_sfr_rdata), .o_addr(i_sfr_addr), .o_wr(i_sfr_wr),
    .o_rd(i_sfr_rd), .o_wdata(i_sfr_wdata));
  always #10 i_mclk = ~i_mclk;
  always @(negedge i_mclk) if (probe_run) i_sysclk_probe <= ~i_sysclk_probe;
  task final_report;
    begin
      $display("checked %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  task chk_rd(input [7:0] a, input [7:0] exp);
    begin
      core_u.rd(a, d);
      checked = checked + 1;
      if (d !== exp) begin
        err_count = err_count + 1;
        $display("[ERR] reg %h exp %h got %h", a, exp, d);
      end
    end
  endtask
  task chk_lvl(input string nm, input exp, input got);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("[ERR] %s exp %b got %b", nm, exp, got);
      end
    end
  endtask
  // Bounded wait on the system reset level
  task wait_lvl(input v);
    begin
      for (k = 0; k < 400 && o_sys_rst !== v; k = k + 1) @(negedge i_mclk);
      if (k == 400) begin
        chk_lvl("sys_rst wait", v, ~v);
        final_report;
      end
    end
  endtask
  task after_rst(input [7:0] flags);
    begin
      wait_lvl(1'b0);
      m_lvl = 0;
      chk_rd(8'hEF, flags);
      $display("test flags %h done", flags);
    end
  endtask
  function [7:0] mon_exp;
    input x;
    mon_exp = {m_en[0], i_supply_above, m_lvl[0], 5'h00};
  endfunction
  initial begin
    repeat (16) @(negedge i_mclk);
    i_rst = 1'b0;
    after_rst(8'h02);
    chk_rd(8'hFF, mon_exp(0));
    r = $random(seed);
    chk_rd({4'h8, r[3:0]}, 8'h00);
    // Enable forced off so the low supply below must not reset
    core_u.wr(8'hFF, r[15:8] & 8'h7F);
    m_en = 0;
    m_lvl = r[13];
    chk_rd(8'hFF, mon_exp(0));
    chk_lvl("mon_en", m_en[0], o_supply_monitor_enable);
    chk_lvl("lvl", m_lvl[0], o_supply_threshold_select);
    i_supply_above = 1'b0;
    repeat (6) @(negedge i_mclk);
    chk_rd(8'hFF, mon_exp(0));
    chk_lvl("sys_rst", 1'b0, o_sys_rst);
    i_supply_above = 1'b1;
    repeat (4) @(negedge i_mclk);
    core_u.wr(8'hEF, 8'h10);
    wait_lvl(1'b1);
    chk_lvl("pin_oe", 1'b0, o_rst_pin_oe);
    after_rst(8'h10);
    chk_rd(8'hFF, mon_exp(0));
    i_rst_pin_n = 1'b0;
    wait_lvl(1'b1);
    repeat (5) @(negedge i_mclk);
    i_rst_pin_n = 1'b1;
    after_rst(8'h01);
    i_wdt_expire = 1'b1;
    @(negedge i_mclk);
    i_wdt_expire = 1'b0;
    wait_lvl(1'b1);
    after_rst(8'h08);
    // Comparator output already settled high before selection
    core_u.wr(8'hEF, 8'h20);
    i_cmp_out = 1'b0;
    wait_lvl(1'b1);
    repeat (30) @(negedge i_mclk);
    chk_lvl("cmp hold", 1'b1, o_sys_rst);
    i_cmp_out = 1'b1;
    after_rst(8'h20);
    core_u.wr(8'hEF, 8'h04);
    probe_run = 1'b0;
    wait_lvl(1'b1);
    probe_run = 1'b1;
    after_rst(8'h04);
    // Monitor enabled first, then selected
    core_u.wr(8'hFF, 8'h80);
    m_en = 1;
    core_u.wr(8'hEF, 8'h02);
    i_supply_above = 1'b0;
    wait_lvl(1'b1);
    chk_lvl("pin_oe", 1'b1, o_rst_pin_oe);
    i_supply_above = 1'b1;
    after_rst(8'h02);
    for (r = 0; r < 5; r = r + 1) begin
      i_bank = 2'h3;
      i_fetch_bank = 2'h3;
      i_addr = 16'hFC00 | $random(seed);
      i_fetch_addr = i_addr;
      i_code_rd = r == 0;
      i_fetch = r == 1;
      i_program_store_write_enable = r == 2;
      i_data_wr = r == 2;
      i_secure_deny = r == 3;
      i_flash_op = r > 2;
      @(negedge i_mclk);
      {i_code_rd, i_fetch, i_program_store_write_enable, i_data_wr, i_secure_deny, i_flash_op} = 6'h00;
      wait_lvl(1'b1);
      after_rst(8'h40);
    end
    i_addr = 16'hFBFF;
    i_code_rd = 1'b1;
    @(negedge i_mclk);
    i_code_rd = 1'b0;
    repeat (8) @(negedge i_mclk);
    chk_lvl("legal read", 1'b0, o_sys_rst);
    final_report;
  end
endmodule

/* verilog/rsc_clk_loss.v */
/*
  Clock loss one-shot: times out when the clock probe stops toggling.
  Assumes the probe is a clock-tree sample from outside this clock domain.
*/
`timescale 1ns/1ns
`include "rsc_map.vh"

module rsc_clk_loss #(
  parameter [11:0] TIMEOUT_CYC = `RSC_MCD_CYC
) (
  // Clock and reset
  input wire i_mclk,
  input wire i_rst,
  // Probe and control
  input wire i_probe,
  input wire i_enable,
  // Timeout pulse
  output reg o_timeout
);

  reg [2:0] probe_sync_reg;
  reg [11:0] cnt_reg;

  // Stage 0 feeds only stage 1
  wire edge_seen = probe_sync_reg[2] ^ probe_sync_reg[1];

  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      probe_sync_reg <= 3'h0;
      cnt_reg <= 12'h000;
      o_timeout <= 1'b0;
    end else begin
      probe_sync_reg <= {probe_sync_reg[1:0], i_probe};
      o_timeout <= 1'b0;
      // Retrigger on any edge, high or low stall both time out
      if (edge_seen || !i_enable) begin
        cnt_reg <= 12'h000;
      end else if (cnt_reg >= TIMEOUT_CYC - 12'h001) begin
        cnt_reg <= 12'h000;
        o_timeout <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 12'h001;
      end
    end
  end

endmodule

/* verilog/rsc_ctrl.v */
/*
  Reset source controller: merges all reset requests into one system reset,
  records the cause for software, and holds the supply monitor control register.
  Assumes i_rst is the power-on reset and the core reaches registers over the SFR bus.
*/
`timescale 1ns/1ns
`include "rsc_map.vh"

module rsc_ctrl #(
  parameter SMALL_PART = 0,
  parameter [7:0] HOLD_CYC = `RSC_HOLD_CYC
) (
  // Clock and power-on reset
  input wire i_mclk,
  input wire i_rst,
  // SFR bus
  input wire [7:0] i_sfr_addr,
  input wire i_sfr_wr,
  input wire i_sfr_rd,
  input wire [7:0] i_sfr_wdata,
  output reg [7:0] o_sfr_rdata,
  // External reset pin, open drain
  input wire i_rst_pin_n,
  output reg o_rst_pin_out,
  output reg o_rst_pin_oe,
  // Supply monitor analog side
  input wire i_supply_above,
  output wire o_supply_monitor_enable,
  output wire o_supply_threshold_select,
  // Comparator and clock probe
  input wire i_cmp_out,
  input wire i_sysclk_probe,
  // Watchdog in the counter array
  input wire i_wdt_expire,
  output reg o_wdt_tick,
  // Flash access monitor
  input wire i_program_store_write_enable,
  input wire i_data_wr,
  input wire i_code_rd,
  input wire i_fetch,
  input wire i_flash_op,
  input wire i_secure_deny,
  input wire [1:0] i_bank,
  input wire [15:0] i_addr,
  input wire [1:0] i_fetch_bank,
  input wire [15:0] i_fetch_addr,
  // System reset
  output reg o_sys_rst
);

  localparam ST_RUN = 1'b0;
  localparam ST_HOLD = 1'b1;

  reg state_reg;
  reg state_next;
  reg [7:0] hold_cnt_reg;
  reg [7:0] hold_cnt_next;
  reg [`RSC_NUM_SRC-1:0] cause_reg;
  reg [`RSC_NUM_SRC-1:0] cause_next;
  reg [`RSC_NUM_SRC-1:0] flags_reg;
  reg [`RSC_NUM_SRC-1:0] flags_next;
  reg mon_en_reg;
  reg mon_lvl_reg;
  reg mon_sel_reg;
  reg mcd_en_reg;
  reg cmp_sel_reg;
  reg sw_req_reg;
  reg [3:0] div_cnt_reg;
  reg [2:0] sync0_reg;
  reg [2:0] sync1_reg;

  wire pin_low_s = ~sync1_reg[0];
  wire above_s = sync1_reg[1];
  wire cmp_low_s = ~sync1_reg[2];
  wire mcd_timeout;
  wire flash_fault;
  wire supply_ok = mon_en_reg & mon_lvl_reg & mon_sel_reg;

  wire in_run = (state_reg == ST_RUN);
  wire wr_src = in_run & i_sfr_wr & (i_sfr_addr == `RSC_ADDR_SRC);
  wire wr_mon = in_run & i_sfr_wr & (i_sfr_addr == `RSC_ADDR_MON_CTRL);

  assign o_supply_monitor_enable = mon_en_reg;
  assign o_supply_threshold_select = mon_lvl_reg;

  // Pin, supply and comparator cross in through two flops
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sync0_reg <= 3'h7;
      sync1_reg <= 3'h7;
    end else begin
      sync0_reg <= {i_cmp_out, i_supply_above, i_rst_pin_n};
      sync1_reg <= sync0_reg;
    end
  end

  rsc_clk_loss u_clk_loss (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_probe(i_sysclk_probe),
    .i_enable(mcd_en_reg & in_run),
    .o_timeout(mcd_timeout)
  );

  rsc_flash_guard #(
    .SMALL_PART(SMALL_PART)
  ) u_flash_guard (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_program_store_write_enable(i_program_store_write_enable),
    .i_data_wr(i_data_wr),
    .i_code_rd(i_code_rd),
    .i_fetch(i_fetch),
    .i_flash_op(i_flash_op),
    .i_secure_deny(i_secure_deny),
    .i_bank(i_bank),
    .i_addr(i_addr),
    .i_fetch_bank(i_fetch_bank),
    .i_fetch_addr(i_fetch_addr),
    .i_supply_ok(supply_ok),
    .o_fault(flash_fault)
  );

  // Request vector, laid out like the flag register
  reg [`RSC_NUM_SRC-1:0] req;
  always @* begin
    req = {`RSC_NUM_SRC{1'b0}};
    // Own pin drive must not count as an external reset
    req[`RSC_PIN_BIT] = pin_low_s & ~o_rst_pin_oe;
    req[`RSC_POR_BIT] = mon_en_reg & mon_sel_reg & ~above_s;
    req[`RSC_MCD_BIT] = mcd_timeout;
    req[`RSC_WDT_BIT] = i_wdt_expire & in_run;
    req[`RSC_SW_BIT] = sw_req_reg;
    req[`RSC_CMP_BIT] = cmp_sel_reg & cmp_low_s;
    req[`RSC_FLASH_BIT] = flash_fault & in_run;
  end

  // Level sources keep the device in reset for as long as they last
  wire level_req = req[`RSC_PIN_BIT] | req[`RSC_POR_BIT] | req[`RSC_CMP_BIT];

  always @* begin
    state_next = state_reg;
    hold_cnt_next = hold_cnt_reg;
    cause_next = cause_reg;
    flags_next = flags_reg;
    case (state_reg)
      ST_RUN: begin
        if (|req) begin
          state_next = ST_HOLD;
          hold_cnt_next = 8'h00;
          cause_next = req;
        end
      end
      ST_HOLD: begin
        cause_next = cause_reg | req;
        if (hold_cnt_reg < HOLD_CYC) begin
          hold_cnt_next = hold_cnt_reg + 8'h01;
        end else if (!level_req) begin
          state_next = ST_RUN;
          // Power or monitor reset leaves only its own flag defined
          if (cause_reg[`RSC_POR_BIT]) begin
            flags_next = `RSC_FLAGS_POR;
          end else begin
            // Pin, clock loss, watchdog, software, comparator, flash
            flags_next = cause_reg;
          end
        end
      end
      default: begin
        state_next = ST_HOLD;
        hold_cnt_next = 8'h00;
      end
    endcase
  end

  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= ST_HOLD;
      hold_cnt_reg <= 8'h00;
      cause_reg <= `RSC_FLAGS_POR;
      flags_reg <= `RSC_FLAGS_POR;
      o_sys_rst <= 1'b1;
    end else begin
      state_reg <= state_next;
      hold_cnt_reg <= hold_cnt_next;
      cause_reg <= cause_next;
      flags_reg <= flags_next;
      o_sys_rst <= (state_next == ST_HOLD);
    end
  end

  // Only power or monitor resets pull the pin; internal ones leave it alone
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_rst_pin_oe <= 1'b1;
      o_rst_pin_out <= 1'b0;
    end else begin
      o_rst_pin_oe <= (state_next == ST_HOLD) & cause_next[`RSC_POR_BIT];
      o_rst_pin_out <= 1'b0;
    end
  end

  // Supply monitor control
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      mon_en_reg <= `RSC_MON_EN_POR;
      mon_lvl_reg <= `RSC_MON_LVL_RST;
    end else if (!in_run) begin
      // Enable untouched by system resets
      mon_lvl_reg <= `RSC_MON_LVL_RST;
    end else if (wr_mon) begin
      mon_en_reg <= i_sfr_wdata[`RSC_MON_EN_BIT];
      mon_lvl_reg <= i_sfr_wdata[`RSC_MON_LVL_BIT];
    end
  end

  // Source selects and the software force
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      mon_sel_reg <= 1'b1;
      mcd_en_reg <= 1'b0;
      cmp_sel_reg <= 1'b0;
      sw_req_reg <= 1'b0;
    end else begin
      sw_req_reg <= 1'b0;
      if (state_reg == ST_HOLD && state_next == ST_RUN) begin
        // Selects stay live through the hold so level sources keep it
        mon_sel_reg <= cause_reg[`RSC_POR_BIT];
        mcd_en_reg <= 1'b0;
        cmp_sel_reg <= 1'b0;
      end else if (wr_src) begin
        mon_sel_reg <= i_sfr_wdata[`RSC_POR_BIT];
        mcd_en_reg <= i_sfr_wdata[`RSC_MCD_BIT];
        cmp_sel_reg <= i_sfr_wdata[`RSC_CMP_BIT];
        sw_req_reg <= i_sfr_wdata[`RSC_SW_BIT];
      end
    end
  end

  // Watchdog prescaler, restarted by every reset
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      div_cnt_reg <= 4'h0;
      o_wdt_tick <= 1'b0;
    end else if (o_sys_rst) begin
      div_cnt_reg <= 4'h0;
      o_wdt_tick <= 1'b0;
    end else if (div_cnt_reg == `RSC_WDT_DIV - 1) begin
      div_cnt_reg <= 4'h0;
      o_wdt_tick <= 1'b1;
    end else begin
      div_cnt_reg <= div_cnt_reg + 4'h1;
      o_wdt_tick <= 1'b0;
    end
  end

  // Register read port
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_sfr_rdata <= 8'h00;
    end else if (i_sfr_rd) begin
      case (i_sfr_addr)
        `RSC_ADDR_MON_CTRL: begin
          // Status is the live synchronised comparator of the monitor
          o_sfr_rdata <= {mon_en_reg, above_s, mon_lvl_reg, 5'h00};
        end
        `RSC_ADDR_SRC: begin
          o_sfr_rdata <= {1'b0, flags_reg};
        end
        default: begin
          o_sfr_rdata <= 8'h00;
        end
      endcase
    end
  end

endmodule

/* verilog/rsc_flash_guard.v */
/*
  Flash access guard: flags illegal flash accesses as a one-cycle fault pulse.
  Assumes access strobes come from logic on the system clock.
*/
`timescale 1ns/1ns
`include "rsc_map.vh"

module rsc_flash_guard #(
  parameter SMALL_PART = 0
) (
  // Clock and reset
  input wire i_mclk,
  input wire i_rst,
  // Access strobes
  input wire i_program_store_write_enable,
  input wire i_data_wr,
  input wire i_code_rd,
  input wire i_fetch,
  input wire i_flash_op,
  input wire i_secure_deny,
  input wire [1:0] i_bank,
  input wire [15:0] i_addr,
  input wire [1:0] i_fetch_bank,
  input wire [15:0] i_fetch_addr,
  // Supply monitor fully armed for flash work
  input wire i_supply_ok,
  // Fault pulse
  output reg o_fault
);

  // Beyond user space; small parts lose the whole top bank
  function beyond_user;
    input [1:0] bank;
    input [15:0] addr;
    begin
      beyond_user = (bank == `RSC_TOP_BANK) &&
        ((SMALL_PART != 0) || (addr > `RSC_USER_TOP));
    end
  endfunction

  wire wr_bad = i_program_store_write_enable & i_data_wr & beyond_user(i_bank, i_addr);
  wire rd_bad = i_code_rd & beyond_user(i_bank, i_addr);
  wire fetch_bad = i_fetch & beyond_user(i_fetch_bank, i_fetch_addr);
  wire sec_bad = i_flash_op & i_secure_deny;
  wire sup_bad = i_flash_op & ~i_supply_ok;

  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_fault <= 1'b0;
    end else begin
      o_fault <= wr_bad | rd_bad | fetch_bad | sec_bad | sup_bad;
    end
  end

endmodule

/* verilog/rsc_map.vh */
/*
  Register addresses, bit positions, reset values and timing counts of the reset source controller.
  Assumes a 50 MHz system clock; included by every design file of the block.
*/
`ifndef RSC_MAP_VH
`define RSC_MAP_VH

// Special function register addresses
`define RSC_ADDR_MON_CTRL 8'hFF
`define RSC_ADDR_SRC 8'hEF

// Supply monitor control fields
`define RSC_MON_EN_BIT 7
`define RSC_MON_ABOVE_BIT 6
`define RSC_MON_LVL_BIT 5

// Reset source fields, also the cause vector layout
`define RSC_PIN_BIT 0
`define RSC_POR_BIT 1
`define RSC_MCD_BIT 2
`define RSC_WDT_BIT 3
`define RSC_SW_BIT 4
`define RSC_CMP_BIT 5
`define RSC_FLASH_BIT 6
`define RSC_NUM_SRC 7

// Reset values
`define RSC_FLAGS_POR 7'h02
`define RSC_MON_EN_POR 1'b1
`define RSC_MON_LVL_RST 1'b0

// Flash user space limit
`define RSC_USER_TOP 16'hFBFF
`define RSC_TOP_BANK 2'h3

// Timing
`define RSC_CLK_NS 20
`define RSC_WDT_DIV 12
`define RSC_HOLD_CYC 16
`define RSC_MCD_TIMEOUT_NS 1000
`define RSC_MCD_CYC (`RSC_MCD_TIMEOUT_NS / `RSC_CLK_NS)

`endif
